// ---- rtl/gray_stepper.sv ----
// Two-bit Gray up/down step generator of one channel.
// Assumes step period in clock cycles from the channel compare C register.
`timescale 1ns/100ps
`default_nettype none
module gray_stepper (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Control
   input wire logic enable_in,
   input wire logic down_in,
   input wire logic [qdec_pkg::CNT_W-1:0] period_in,
   // Outputs
   output logic [1:0] gray_out
);

   qdec_pkg::gray_state_t state_reg;
   qdec_pkg::gray_state_t state_next;
   logic [qdec_pkg::CNT_W-1:0] tick_reg;
   logic step;

   // ****************************************
   // Period timer
   // ****************************************
   assign step = enable_in && (tick_reg >= period_in);

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tick_reg <= '0;
      end else if (!enable_in || step) begin
         tick_reg <= '0;
      end else begin
         tick_reg <= tick_reg + 1'b1;
      end
   end

   // ****************************************
   // Gray sequence
   // ****************************************
   always_comb begin
      case (state_reg)
         qdec_pkg::GRAY_00: state_next = down_in ? qdec_pkg::GRAY_10
                                                 : qdec_pkg::GRAY_01;
         qdec_pkg::GRAY_01: state_next = down_in ? qdec_pkg::GRAY_00
                                                 : qdec_pkg::GRAY_11;
         qdec_pkg::GRAY_11: state_next = down_in ? qdec_pkg::GRAY_01
                                                 : qdec_pkg::GRAY_10;
         qdec_pkg::GRAY_10: state_next = down_in ? qdec_pkg::GRAY_11
                                                 : qdec_pkg::GRAY_00;
         default: state_next = qdec_pkg::GRAY_00;
      endcase
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= qdec_pkg::GRAY_00;
      end else if (step) begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         gray_out <= 2'h0;
      end else if (step) begin
         case (state_next)
            qdec_pkg::GRAY_01: gray_out <= 2'h1;
            qdec_pkg::GRAY_11: gray_out <= 2'h3;
            qdec_pkg::GRAY_10: gray_out <= 2'h2;
            default: gray_out <= 2'h0;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_gray_one_bit;
      @(posedge sys_clk_in) disable iff (rst_in)
      $changed(gray_out) |-> $countones(gray_out ^ $past(gray_out)) == 1;
   endproperty
   a_gray_one_bit: assert property (p_gray_one_bit)
      else $error("Gray output changed more than one bit");

   property p_gray_up;
      @(posedge sys_clk_in) disable iff (rst_in)
      (step && !down_in && gray_out == 2'h0) |=> gray_out == 2'h1;
   endproperty
   a_gray_up: assert property (p_gray_up)
      else $error("Gray up step from 00 did not reach 01");

   property p_gray_down;
      @(posedge sys_clk_in) disable iff (rst_in)
      (step && down_in && gray_out == 2'h0) |=> gray_out == 2'h2;
   endproperty
   a_gray_down: assert property (p_gray_down)
      else $error("Gray down step from 00 did not reach 10");

   property p_gray_hold;
      @(posedge sys_clk_in) disable iff (rst_in)
      !enable_in |=> $stable(gray_out);
   endproperty
   a_gray_hold: assert property (p_gray_hold)
      else $error("Gray output moved while disabled");

endmodule
`default_nettype wire

// ---- rtl/qdec_motor.sv ----
// Quadrature position, speed and Gray stepper logic of a three-channel timer.
// Assumes encoder inputs already synchronous to sys_clk_in and a plain
// register port with read data one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none

module qdec_motor (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Encoder
   input wire logic encoder_phase_a_in,
   input wire logic encoder_phase_b_in,
   input wire logic encoder_index_in,
   // Channel waveform outputs
   output logic [2:0] channel_io_a_out,
   output logic [2:0] channel_io_b_out
);

   // ****************************************
   // Register storage
   // ****************************************
   qdec_pkg::chan_cfg_t cfg_reg [qdec_pkg::NCHAN];
   logic [qdec_pkg::CNT_W-1:0] count_reg [qdec_pkg::NCHAN];
   logic [qdec_pkg::NCHAN-1:0] clk_on_reg;
   logic [31:0] block_mode_reg;
   logic write_protect_enable_reg;
   logic direction_reg;
   logic [1:0] phase_reg;
   logic index_reg;
   logic tbase_reg;
   logic [qdec_pkg::CNT_W-1:0] tb_cnt_reg;
   logic [1:0] gray_w [qdec_pkg::NCHAN];

   logic quad_decoder_enable;
   logic position_meas_enable;
   logic speed_meas_enable;
   logic [1:0] chan_sel;
   logic [7:0] reg_off;
   logic chan_hit;
   logic [3:0] ph_now;
   logic ph_step;
   logic ph_dir;
   logic idx_rise;
   logic tb_rise;
   logic tbase_wrap;

   assign quad_decoder_enable = block_mode_reg[qdec_pkg::BMR_QUAD_DECODER_ENABLE];
   assign position_meas_enable = block_mode_reg[qdec_pkg::BMR_POSITION_MEAS_ENABLE];
   assign speed_meas_enable = block_mode_reg[qdec_pkg::BMR_SPEED_MEAS_ENABLE];

   // Channel window decode; above 0xbf lies the block area
   assign chan_sel = reg_addr_in[7:6];
   assign reg_off = {2'h0, reg_addr_in[5:0]};
   assign chan_hit = (chan_sel != 2'h3);

   // ****************************************
   // Quadrature decode
   // ****************************************
   // Inputs are already synchronous, so one stage of history suffices
   assign ph_now = {phase_reg, encoder_phase_a_in, encoder_phase_b_in};
   always_comb begin
      ph_step = 1'b0;
      ph_dir = direction_reg;
      case (ph_now)
         4'h1, 4'h7, 4'he, 4'h8: begin
            ph_step = 1'b1;
            ph_dir = 1'b1;
         end
         4'h2, 4'hb, 4'hd, 4'h4: begin
            ph_step = 1'b1;
            ph_dir = 1'b0;
         end
         default: begin
            ph_step = 1'b0;
            ph_dir = direction_reg;
         end
      endcase
   end

   assign idx_rise = encoder_index_in && !index_reg;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         phase_reg <= 2'h0;
         index_reg <= 1'b0;
         direction_reg <= 1'b0;
      end else begin
         phase_reg <= {encoder_phase_a_in, encoder_phase_b_in};
         index_reg <= encoder_index_in;
         if (quad_decoder_enable && ph_step) begin
            direction_reg <= ph_dir;
         end
      end
   end

   // ****************************************
   // Channel 2 time base
   // ****************************************
   // Clear on C compare and toggle of the A line give the speed window
   assign tbase_wrap = clk_on_reg[2] &&
                       (tb_cnt_reg >= cfg_reg[2].rc);
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tb_cnt_reg <= '0;
         tbase_reg <= 1'b0;
      end else if (reg_wr_in && chan_sel == 2'h2 &&
                   reg_off == qdec_pkg::OFF_CCR &&
                   reg_wdata_in[qdec_pkg::CCR_SOFT_TRIGGER_CMD]) begin
         tb_cnt_reg <= '0;
      end else if (tbase_wrap) begin
         tb_cnt_reg <= '0;
         tbase_reg <= !tbase_reg;
      end else if (clk_on_reg[2]) begin
         tb_cnt_reg <= tb_cnt_reg + 1'b1;
      end
   end

   // Internal feedback of the time base into channel 0 A input
   logic tbase_prev_reg;
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tbase_prev_reg <= 1'b0;
      end else begin
         tbase_prev_reg <= tbase_reg;
      end
   end
   assign tb_rise = quad_decoder_enable && speed_meas_enable &&
                    tbase_reg && !tbase_prev_reg;

   // ****************************************
   // Channel clocks
   // ****************************************
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         clk_on_reg <= '0;
      end else if (reg_wr_in && chan_hit && reg_off == qdec_pkg::OFF_CCR) begin
         if (reg_wdata_in[qdec_pkg::CCR_COUNTER_CLOCK_OFF_CMD]) begin
            clk_on_reg[chan_sel] <= 1'b0;
         end else if (reg_wdata_in[qdec_pkg::CCR_COUNTER_CLOCK_ON_CMD] ||
                      reg_wdata_in[qdec_pkg::CCR_SOFT_TRIGGER_CMD]) begin
            clk_on_reg[chan_sel] <= 1'b1;
         end
      end
   end

   // ****************************************
   // Position, revolution and speed counters
   // ****************************************
   logic soft_trigger_cmd [qdec_pkg::NCHAN];
   logic rev_inc;
   assign rev_inc = position_meas_enable && clk_on_reg[1] && idx_rise;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         count_reg[0] <= '0;
      end else if (soft_trigger_cmd[0]) begin
         count_reg[0] <= '0;
      end else if (speed_meas_enable && tb_rise) begin
         count_reg[0] <= '0;
      end else if (rev_inc && direction_reg) begin
         count_reg[0] <= '0;
      end else if ((position_meas_enable || speed_meas_enable) &&
                   clk_on_reg[0] && ph_step) begin
         if (ph_dir) begin
            count_reg[0] <= count_reg[0] + 1'b1;
         end else begin
            count_reg[0] <= count_reg[0] - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         count_reg[1] <= '0;
      end else if (soft_trigger_cmd[1]) begin
         count_reg[1] <= '0;
      end else if (rev_inc) begin
         if (direction_reg) begin
            count_reg[1] <= count_reg[1] + 1'b1;
         end else begin
            count_reg[1] <= count_reg[1] - 1'b1;
         end
      end
   end

   // Channel 2 counter mirrors the time base count
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         count_reg[2] <= '0;
      end else begin
         count_reg[2] <= tb_cnt_reg;
      end
   end

   // ****************************************
   // Configuration and capture registers
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < qdec_pkg::NCHAN; g++) begin : g_chan
         logic wr_here;
         assign wr_here = reg_wr_in && chan_sel == g &&
                          !write_protect_enable_reg;
         assign soft_trigger_cmd[g] = reg_wr_in && chan_sel == g &&
                           reg_off == qdec_pkg::OFF_CCR &&
                           reg_wdata_in[qdec_pkg::CCR_SOFT_TRIGGER_CMD];
         always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
               cfg_reg[g] <= '0;
            end else begin
               if (wr_here && reg_off == qdec_pkg::OFF_CMR) begin
                  cfg_reg[g].mode <= reg_wdata_in;
               end
               if (wr_here && reg_off == qdec_pkg::OFF_SMMR) begin
                  cfg_reg[g].stepper <= reg_wdata_in[1:0];
               end
               if (wr_here && reg_off == qdec_pkg::OFF_RB) begin
                  cfg_reg[g].rb <= reg_wdata_in[qdec_pkg::CNT_W-1:0];
               end
               if (wr_here && reg_off == qdec_pkg::OFF_RC) begin
                  cfg_reg[g].rc <= reg_wdata_in[qdec_pkg::CNT_W-1:0];
               end
               if (g == 0 && speed_meas_enable && tb_rise) begin
                  cfg_reg[g].ra <= count_reg[0];
               end else if (wr_here && reg_off == qdec_pkg::OFF_RA) begin
                  cfg_reg[g].ra <= reg_wdata_in[qdec_pkg::CNT_W-1:0];
               end
            end
         end

         // Waveform mode is left to software; enable bit alone steers it
         gray_stepper u_gray (
            .sys_clk_in(sys_clk_in),
            .rst_in(rst_in),
            .enable_in(cfg_reg[g].stepper[qdec_pkg::SMMR_GRAY_COUNTER_ENABLE]),
            .down_in(cfg_reg[g].stepper[qdec_pkg::SMMR_DOWN]),
            .period_in(cfg_reg[g].rc),
            .gray_out(gray_w[g])
         );

         always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
               channel_io_a_out[g] <= 1'b0;
               channel_io_b_out[g] <= 1'b0;
            end else begin
               channel_io_a_out[g] <= gray_w[g][1];
               channel_io_b_out[g] <= gray_w[g][0];
            end
         end
      end
   endgenerate

   // ****************************************
   // Block registers
   // ****************************************
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         block_mode_reg <= qdec_pkg::REG_RST;
         write_protect_enable_reg <= 1'b0;
      end else if (reg_wr_in) begin
         if (reg_addr_in == qdec_pkg::OFF_BMR && !write_protect_enable_reg) begin
            block_mode_reg <= reg_wdata_in;
         end
         if (reg_addr_in == qdec_pkg::OFF_WPMR) begin
            write_protect_enable_reg <= reg_wdata_in[qdec_pkg::WPMR_WRITE_PROTECT_ENABLE];
         end
      end
   end

   // ****************************************
   // Read data, one cycle after the strobe
   // ****************************************
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= '0;
      end else if (!reg_rd_in) begin
         reg_rdata_out <= '0;
      end else if (chan_hit) begin
         case (reg_off)
            qdec_pkg::OFF_CMR: reg_rdata_out <= cfg_reg[chan_sel].mode;
            qdec_pkg::OFF_SMMR:
               reg_rdata_out <= {30'h0, cfg_reg[chan_sel].stepper};
            qdec_pkg::OFF_CV:
               reg_rdata_out <= {16'h0, count_reg[chan_sel]};
            qdec_pkg::OFF_RA: reg_rdata_out <= {16'h0, cfg_reg[chan_sel].ra};
            qdec_pkg::OFF_RB: reg_rdata_out <= {16'h0, cfg_reg[chan_sel].rb};
            qdec_pkg::OFF_RC: reg_rdata_out <= {16'h0, cfg_reg[chan_sel].rc};
            qdec_pkg::OFF_SR:
               reg_rdata_out <= {15'h0, clk_on_reg[chan_sel], 16'h0};
            default: reg_rdata_out <= '0;
         endcase
      end else begin
         case (reg_addr_in)
            qdec_pkg::OFF_BMR: reg_rdata_out <= block_mode_reg;
            qdec_pkg::OFF_QISR:
               reg_rdata_out <= {23'h0, direction_reg, 8'h0};
            qdec_pkg::OFF_WPMR:
               reg_rdata_out <= {31'h0, write_protect_enable_reg};
            default: reg_rdata_out <= '0;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_wp_blocks_bmr;
      @(posedge sys_clk_in) disable iff (rst_in)
      write_protect_enable_reg |=> $stable(block_mode_reg);
   endproperty
   a_wp_blocks_bmr: assert property (p_wp_blocks_bmr)
      else $error("Block mode changed under write protect");

   property p_rev_clears_pos;
      @(posedge sys_clk_in) disable iff (rst_in)
      (rev_inc && direction_reg && !soft_trigger_cmd[0] && !tb_rise)
         |=> count_reg[0] == '0;
   endproperty
   a_rev_clears_pos: assert property (p_rev_clears_pos)
      else $error("Position not cleared on revolution");

   property p_speed_capture;
      @(posedge sys_clk_in) disable iff (rst_in)
      (speed_meas_enable && tb_rise) |=>
         cfg_reg[0].ra == $past(count_reg[0]) && count_reg[0] == '0;
   endproperty
   a_speed_capture: assert property (p_speed_capture)
      else $error("Speed capture or clear missed");

   property p_counter_clock_off_cmd_wins;
      @(posedge sys_clk_in) disable iff (rst_in)
      (reg_wr_in && chan_sel == 2'h0 && reg_off == qdec_pkg::OFF_CCR &&
       reg_wdata_in[qdec_pkg::CCR_COUNTER_CLOCK_OFF_CMD]) |=> !clk_on_reg[0];
   endproperty
   a_counter_clock_off_cmd_wins: assert property (p_counter_clock_off_cmd_wins)
      else $error("Clock still on after disable");

   property p_soft_trigger_cmd_resets;
      @(posedge sys_clk_in) disable iff (rst_in)
      soft_trigger_cmd[1] |=> count_reg[1] == '0 && clk_on_reg[1];
   endproperty
   a_soft_trigger_cmd_resets: assert property (p_soft_trigger_cmd_resets)
      else $error("Software trigger did not reset and start");

   property p_pos_up;
      @(posedge sys_clk_in) disable iff (rst_in)
      (position_meas_enable && !speed_meas_enable && clk_on_reg[0] &&
       ph_step && ph_dir && !soft_trigger_cmd[0] && !rev_inc)
         |=> count_reg[0] == $past(count_reg[0]) + 1'b1;
   endproperty
   a_pos_up: assert property (p_pos_up)
      else $error("Position did not count up");

   property p_rev_count;
      @(posedge sys_clk_in) disable iff (rst_in)
      (rev_inc && direction_reg && !soft_trigger_cmd[1])
         |=> count_reg[1] == $past(count_reg[1]) + 1'b1;
   endproperty
   a_rev_count: assert property (p_rev_count)
      else $error("Revolution count did not increment");

   property p_read_latency;
      @(posedge sys_clk_in) disable iff (rst_in)
      !reg_rd_in |=> reg_rdata_out == '0;
   endproperty
   a_read_latency: assert property (p_read_latency)
      else $error("Read data outside read cycle");

   c_rev: cover property (@(posedge sys_clk_in) disable iff (rst_in)
      rev_inc);
   c_speed: cover property (@(posedge sys_clk_in) disable iff (rst_in)
      speed_meas_enable && tb_rise);
   c_wp: cover property (@(posedge sys_clk_in) disable iff (rst_in)
      write_protect_enable_reg && reg_wr_in);
   c_gray: cover property (@(posedge sys_clk_in) disable iff (rst_in)
      channel_io_a_out[0] && channel_io_b_out[0]);

endmodule
`default_nettype wire

// ---- rtl/qdec_pkg.sv ----
// Package for the quadrature position, speed and Gray counter block.
// Assumes a single 250 MHz clock and the plain register port of the top.
package qdec_pkg;

   // ****************************************
   // Register offsets (byte addresses, one word each)
   // ****************************************
   localparam logic [7:0] CHAN_STRIDE = 8'h40;
   localparam logic [7:0] OFF_CCR = 8'h00;
   localparam logic [7:0] OFF_CMR = 8'h04;
   localparam logic [7:0] OFF_SMMR = 8'h08;
   localparam logic [7:0] OFF_CV = 8'h10;
   localparam logic [7:0] OFF_RA = 8'h14;
   localparam logic [7:0] OFF_RB = 8'h18;
   localparam logic [7:0] OFF_RC = 8'h1c;
   localparam logic [7:0] OFF_SR = 8'h20;
   localparam logic [7:0] OFF_BMR = 8'hc4;
   localparam logic [7:0] OFF_QISR = 8'hd4;
   localparam logic [7:0] OFF_WPMR = 8'he4;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CCR_COUNTER_CLOCK_ON_CMD = 0;
   localparam int CCR_COUNTER_CLOCK_OFF_CMD = 1;
   localparam int CCR_SOFT_TRIGGER_CMD = 2;
   localparam int CMR_ETRG_LSB = 8;
   localparam int CMR_TRIGGER_SOURCE_SEL = 10;
   localparam int CMR_WAVE = 15;
   localparam int CMR_CAPTURE_A_LOAD_EDGE_LSB = 16;
   localparam int SMMR_GRAY_COUNTER_ENABLE = 0;
   localparam int SMMR_DOWN = 1;
   localparam int BMR_QUAD_DECODER_ENABLE = 8;
   localparam int BMR_POSITION_MEAS_ENABLE = 9;
   localparam int BMR_SPEED_MEAS_ENABLE = 10;
   localparam int QISR_DIR = 8;
   localparam int WPMR_WRITE_PROTECT_ENABLE = 0;
   localparam int SR_CLKSTA = 16;

   // ****************************************
   // Reset values and widths
   // ****************************************
   localparam int CNT_W = 16;
   localparam int NCHAN = 3;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam logic [1:0] EDGE_RISING = 2'h1;

   // Control bundle of one channel
   typedef struct packed {
      logic [31:0] mode;
      logic [1:0] stepper;
      logic [CNT_W-1:0] ra;
      logic [CNT_W-1:0] rb;
      logic [CNT_W-1:0] rc;
   } chan_cfg_t;

   // Gray counter step states, one-hot
   typedef enum logic [3:0] {
      GRAY_00 = 4'h1,
      GRAY_01 = 4'h2,
      GRAY_11 = 4'h4,
      GRAY_10 = 4'h8
   } gray_state_t;

endpackage

// ---- tb/encoder_model.sv ----
// Rotary encoder model: quadrature phases and an index pulse.
// Assumes the bench pulses step_in for one cycle with dir_in steady.
`timescale 1ns/100ps
`default_nettype none
module encoder_model (
   // Clock
   input wire logic sys_clk_in,
   // Commands
   input wire logic step_in,
   input wire logic dir_in,
   input wire logic index_in,
   // Encoder lines
   output logic phase_a_out,
   output logic phase_b_out,
   output logic index_out
);
   logic [1:0] pos_reg = 2'h0;
   // Only one phase moves per step, so no illegal jumps
   always_ff @(posedge sys_clk_in) begin
      if (step_in) begin
         pos_reg <= dir_in ? pos_reg + 2'h1 : pos_reg - 2'h1;
      end
      index_out <= index_in;
   end
   assign phase_a_out = pos_reg[1];
   assign phase_b_out = pos_reg[1] ^ pos_reg[0];
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the quadrature, speed and Gray counter block.
// Assumes the encoder model and the register map of the package.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic [7:0] wa;
      logic [31:0] wd;
      logic [7:0] ra;
      logic [31:0] ex;
   } row_t;
   row_t rows [10] = '{
      '{8'h04, 32'h10500, 8'h04, 32'h10500}, '{8'h44, 32'h500, 8'h44, 32'h500},
      '{8'h00, 32'h5, 8'h20, 32'h10000}, '{8'h40, 32'h5, 8'h60, 32'h10000},
      '{8'h40, 32'h3, 8'h60, 32'h0}, '{8'h40, 32'h1, 8'h60, 32'h10000},
      '{8'h0c, 32'hffff, 8'h0c, 32'h0}, '{8'h84, 32'h3c000, 8'h84, 32'h3c000},
      '{8'h9c, 32'h3, 8'h9c, 32'h3}, '{8'hc4, 32'h300, 8'hc4, 32'h300}};
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic step = 1'b0;
   logic dir = 1'b1;
   logic idx = 1'b0;
   logic pa, pb, pi;
   logic [31:0] rdata;
   logic [2:0] io_a, io_b;
   int error_cnt = 0;
   int check_count = 0;
   always #2 sys_clk_in = ~sys_clk_in;
   encoder_model enc (.sys_clk_in(sys_clk_in), .step_in(step), .dir_in(dir),
      .index_in(idx), .phase_a_out(pa), .phase_b_out(pb), .index_out(pi));
   qdec_motor DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .encoder_phase_a_in(pa),
      .encoder_phase_b_in(pb), .encoder_index_in(pi),
      .channel_io_a_out(io_a), .channel_io_b_out(io_b));
   task automatic stop_test;
      if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_in);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_in);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd_reg(a, d);
      chk(d, e);
   endtask
   task automatic turn(input int n, input logic d);
      repeat (n) begin
         @(posedge sys_clk_in);
         step <= 1'b1;
         dir <= d;
         @(posedge sys_clk_in);
         step <= 1'b0;
      end
      repeat (3) @(posedge sys_clk_in);
   endtask
   task automatic index_pulse;
      @(posedge sys_clk_in);
      idx <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      idx <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
   endtask
   // Steps must follow the Gray order, RC2 + 1 cycles apart
   task automatic gray_watch(input logic down);
      logic [1:0] prev;
      logic [1:0] now;
      int gap;
      int seen;
      // A step launched with the old direction may still be in the output flop
      @(posedge sys_clk_in);
      #1 prev = {io_a[2], io_b[2]};
      gap = 0;
      seen = 0;
      repeat (40) begin
         @(posedge sys_clk_in);
         #1 now = {io_a[2], io_b[2]};
         gap++;
         if (now !== prev) begin
            chk(32'(now), down ? {~prev[0], prev[1]} : {prev[0], ~prev[1]});
            if (seen > 0) chk(32'(gap), 32'h4);
            seen++;
            gap = 0;
            prev = now;
         end
      end
      chk(32'(seen > 5), 32'h1);
   endtask
   initial begin : main
      logic [31:0] d;
      int n;
      repeat (2) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      chk({26'h0, io_a, io_b}, 32'h0);
      rd_chk(8'h10, 32'h0);
      for (int i = 0; i < 10; i++) begin
         wr_reg(rows[i].wa, rows[i].wd);
         rd_chk(rows[i].ra, rows[i].ex);
      end
      turn(5, 1'b1);
      rd_chk(8'h10, 32'h5);
      rd_chk(8'hd4, 32'h100);
      turn(2, 1'b0);
      rd_chk(8'h10, 32'h3);
      rd_chk(8'hd4, 32'h0);
      turn(1, 1'b1);
      index_pulse();
      rd_chk(8'h50, 32'h1);
      rd_chk(8'h10, 32'h0);
      turn(3, 1'b1);
      wr_reg(8'he4, 32'h1);
      wr_reg(8'h1c, 32'h55);
      wr_reg(8'hc4, 32'h0);
      rd_chk(8'h1c, 32'h0);
      rd_chk(8'hc4, 32'h300);
      wr_reg(8'he4, 32'h0);
      wr_reg(8'h80, 32'h5);
      wr_reg(8'hc4, 32'h700);
      n = 0;
      do begin
         rd_reg(8'h14, d);
         n++;
      end while (d !== 32'h3 && n < 20);
      chk(d, 32'h3);
      if (n >= 20) stop_test();
      index_pulse();
      rd_chk(8'h50, 32'h2);
      wr_reg(8'h88, 32'h1);
      gray_watch(1'b0);
      wr_reg(8'h88, 32'h3);
      gray_watch(1'b1);
      stop_test();
   end
endmodule
`default_nettype wire
